// [hdl/wakirq_top.sv]
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
// wake qualification and main interrupt signalling
module wakirq_top (
	input wire logic mclk,
	input wire logic rst,
	input wire logic level_input_a_hi,
	input wire logic level_input_a_lo,
	input wire logic level_input_a_alo,
	input wire logic level_input_b_hi,
	input wire logic level_input_b_lo,
	input wire logic level_input_b_alo,
	input wire logic standby_mode,
	input wire logic [22:0] fault_evt,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq_pulse_out_n_o,
	output logic irq_pulse_out_n_oe,
	output logic bias_on,
	output logic level_state_a,
	output logic level_state_b,
	output logic irq
);
	wakirq_evt_if evt ();
	logic wake_a_chg; // filtered transition strobes
	logic wake_b_chg;
	logic aa1_r, aa2_r, ab1_r, ab2_r; // analog-low syncs
	logic sb1_r, sb2_r; // standby sync
	logic bias_r;
	logic [22:0] status_r; // sticky events
	logic [22:0] mask_r; // irq output mask, 1 = enabled
	logic [22:0] inhibit_r; // per-source pin inhibit
	logic [22:0] pend_r; // events waiting for a pulse
	logic [22:0] ev_all;
	logic [22:0] ev_pin;
	logic [22:0] w1c;
	logic link_sw_r; // software-raised link fault
	logic [31:0] rdata_r;

	// per-input level filters
	wakirq_filter #(.FILT_CYC(wakirq_pkg::WAKE_FILT_CYC)) u_fa (
		.mclk(mclk),
		.rst(rst),
		.raw_hi(level_input_a_hi),
		.raw_lo(level_input_a_lo),
		.state(level_state_a),
		.changed(wake_a_chg)
	);
	wakirq_filter #(.FILT_CYC(wakirq_pkg::WAKE_FILT_CYC)) u_fb (
		.mclk(mclk),
		.rst(rst),
		.raw_hi(level_input_b_hi),
		.raw_lo(level_input_b_lo),
		.state(level_state_b),
		.changed(wake_b_chg)
	);
	wakirq_pulse u_pulse (
		.mclk(mclk),
		.rst(rst),
		.evt(evt.gen)
	);

	// sync analog-low comparators and standby flag
	always_ff @(posedge mclk) begin
		if (rst) begin
			aa1_r <= 1'b0;
			aa2_r <= 1'b0;
			ab1_r <= 1'b0;
			ab2_r <= 1'b0;
			sb1_r <= 1'b0;
			sb2_r <= 1'b0;
		end else begin
			aa1_r <= level_input_a_alo;
			aa2_r <= aa1_r;
			ab1_r <= level_input_b_alo;
			ab2_r <= ab1_r;
			sb1_r <= standby_mode;
			sb2_r <= sb1_r;
		end
	end

	// bias control: start wins over stop
	always_ff @(posedge mclk) begin
		if (rst) begin
			bias_r <= 1'b0;
		end else if (level_state_a || level_state_b) begin
			bias_r <= 1'b1;
		end else if (sb2_r && aa2_r && ab2_r) begin
			bias_r <= 1'b0;
		end
	end
	assign bias_on = bias_r;

	// event vector: faults from analog, wake edges, link errors
	always_comb begin
		ev_all = fault_evt;
		ev_all[wakirq_pkg::EV_WAKE_A] = wake_a_chg;
		ev_all[wakirq_pkg::EV_WAKE_B] = wake_b_chg;
		ev_all[wakirq_pkg::EV_LINK] = fault_evt[wakirq_pkg::EV_LINK] | link_sw_r;
	end
	assign ev_pin = ev_all & ~inhibit_r;

	// write-one-to-clear decode
	always_comb begin
		w1c = '0;
		if (reg_wr && reg_addr == wakirq_pkg::ADDR_STATUS) begin
			w1c = reg_wdata[22:0];
		end
	end

	// sticky status, new event beats the clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			status_r <= '0;
		end else begin
			status_r <= (status_r & ~w1c) | ev_all;
		end
	end

	// pending pulses: events queued while busy share one pulse
	always_ff @(posedge mclk) begin
		if (rst) begin
			pend_r <= '0;
		end else if (!evt.busy && pend_r != 23'h000000) begin
			pend_r <= ev_pin;
		end else begin
			pend_r <= pend_r | ev_pin;
		end
	end
	// a pending bit whose source later gets inhibited still fires once
	assign evt.req = !evt.busy && (pend_r != 23'h000000);

	// control registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			mask_r <= wakirq_pkg::MASK_RST;
			inhibit_r <= wakirq_pkg::INHIBIT_RST;
			link_sw_r <= 1'b0;
		end else begin
			link_sw_r <= 1'b0;
			if (reg_wr) begin
				case (reg_addr)
					wakirq_pkg::ADDR_MASK: mask_r <= reg_wdata[22:0];
					wakirq_pkg::ADDR_INHIBIT: inhibit_r <= reg_wdata[22:0];
					wakirq_pkg::ADDR_CTRL: link_sw_r <= reg_wdata[0];
					default: ;
				endcase
			end
		end
	end

	// read mux, data valid the cycle after the strobe
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_r <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				wakirq_pkg::ADDR_STATUS: rdata_r <= {9'h000, status_r};
				wakirq_pkg::ADDR_MASK: rdata_r <= {9'h000, mask_r};
				wakirq_pkg::ADDR_INHIBIT: rdata_r <= {9'h000, inhibit_r};
				wakirq_pkg::ADDR_WAKE: rdata_r <= {28'h0000000, evt.busy, bias_r,
					level_state_b, level_state_a};
				default: rdata_r <= '0;
			endcase
		end else begin
			rdata_r <= '0;
		end
	end
	assign reg_rdata = rdata_r;

	// pin: output value is always low, enable does the pulling
	assign irq_pulse_out_n_o = 1'b0;
	assign irq_pulse_out_n_oe = evt.pin_oe;
	assign irq = |(status_r & mask_r);
endmodule // wakirq_top

// [shared/wakirq_pkg.sv]
package wakirq_pkg;
	// event vector layout, one bit per main-logic source
	localparam int unsigned NUM_SRC = 23;
	localparam int unsigned EV_SUP_UV7 = 0;
	localparam int unsigned EV_SUP_UVH = 1;
	localparam int unsigned EV_SUP_UVL = 2;
	localparam int unsigned EV_BIAS_UVH = 3;
	localparam int unsigned EV_PRE_OC = 4;
	localparam int unsigned EV_PRE_OV = 5;
	localparam int unsigned EV_PRE_UVH = 6;
	localparam int unsigned EV_BUCK_BASE = 7;
	localparam int unsigned EV_STEP_TSD = 13;
	localparam int unsigned EV_STEP_OV = 14;
	localparam int unsigned EV_STEP_UVH = 15;
	localparam int unsigned EV_LDO_BASE = 16;
	localparam int unsigned EV_WAKE_A = 20;
	localparam int unsigned EV_WAKE_B = 21;
	localparam int unsigned EV_LINK = 22;
	// register indices
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_MASK = 4'h1;
	localparam logic [3:0] ADDR_INHIBIT = 4'h2;
	localparam logic [3:0] ADDR_WAKE = 4'h3;
	localparam logic [3:0] ADDR_CTRL = 4'h4;
	localparam logic [22:0] MASK_RST = 23'h7fffff;
	localparam logic [22:0] INHIBIT_RST = 23'h000000;
	// timing
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned WAKE_FILT_US = 70;
	localparam int unsigned WAKE_FILT_CYC = WAKE_FILT_US * CLK_MHZ;
	localparam int unsigned PULSE_US = 100;
	localparam int unsigned PULSE_CYC = PULSE_US * CLK_MHZ;
	localparam int unsigned CNT_W = 14;
endpackage

// [shared/wakirq_evt_if.sv]
`timescale 1ns/10ps
// event hand-off from pulse engine request side
interface wakirq_evt_if;
	logic req; // one-cycle event request
	logic busy; // pulse in progress
	logic pin_oe; // drive pin low
	modport src (output req, input busy, input pin_oe);
	modport gen (input req, output busy, output pin_oe);
endinterface // wakirq_evt_if

// [hdl/wakirq_filter.sv]
`timescale 1ns/10ps
// level filter for one wake input
module wakirq_filter #(
	parameter int unsigned FILT_CYC = 7000
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic raw_hi,
	input wire logic raw_lo,
	output logic state,
	output logic changed
);
	logic s1_r; // sync stage one
	logic s2_r; // sync stage two
	logic l1_r;
	logic l2_r;
	logic [13:0] cnt_r; // stable counter
	logic state_r;
	logic want;
	// two-flop synchronisers for the comparator outputs
	always_ff @(posedge mclk) begin
		if (rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			l1_r <= 1'b1;
			l2_r <= 1'b1;
		end else begin
			s1_r <= raw_hi;
			s2_r <= s1_r;
			l1_r <= raw_lo;
			l2_r <= l1_r;
		end
	end
	// hysteresis: high needs high comparator, low needs low comparator
	always_comb begin
		want = state_r;
		if (s2_r) begin
			want = 1'b1;
		end else if (l2_r) begin
			want = 1'b0;
		end
	end
	// short glitches restart the counter and never reach the state
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_r <= 14'h0000;
			state_r <= 1'b0;
			changed <= 1'b0;
		end else begin
			changed <= 1'b0;
			if (want == state_r) begin
				cnt_r <= 14'h0000;
			end else if (cnt_r == 14'(FILT_CYC - 1)) begin
				cnt_r <= 14'h0000;
				state_r <= want;
				changed <= 1'b1;
			end else begin
				cnt_r <= cnt_r + 14'h0001;
			end
		end
	end
	assign state = state_r;
endmodule // wakirq_filter

// [hdl/wakirq_pulse.sv]
`timescale 1ns/10ps
// fixed-length low pulse generator for the interrupt pin
module wakirq_pulse (
	input wire logic mclk,
	input wire logic rst,
	wakirq_evt_if.gen evt
);
	typedef enum logic [1:0] {
		WPS_IDLE = 2'b01,
		WPS_LOW = 2'b10
	} wakirq_pst_t;
	wakirq_pst_t st_r;
	logic [wakirq_pkg::CNT_W-1:0] cnt_r;
	// one request opens one pulse of fixed width
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_r <= WPS_IDLE;
			cnt_r <= '0;
		end else begin
			case (st_r)
				WPS_IDLE: begin
					if (evt.req) begin
						st_r <= WPS_LOW;
						cnt_r <= '0;
					end
				end
				WPS_LOW: begin
					if (cnt_r == wakirq_pkg::CNT_W'(wakirq_pkg::PULSE_CYC - 1)) begin
						st_r <= WPS_IDLE;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				default: st_r <= WPS_IDLE;
			endcase
		end
	end
	// open drain: only ever pull low, pull-up does the rest
	assign evt.pin_oe = (st_r == WPS_LOW);
	assign evt.busy = (st_r == WPS_LOW);
endmodule // wakirq_pulse

// [test/wakirq_top_properties.sv]
`timescale 1ns/10ps
// pin, wake and bias relations seen at the top ports
module wakirq_top_chk (
	input wire logic mclk,
	input wire logic rst,
	input wire logic level_input_a_hi,
	input wire logic level_input_a_lo,
	input wire logic standby_mode,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic irq_pulse_out_n_o,
	input wire logic irq_pulse_out_n_oe,
	input wire logic bias_on,
	input wire logic level_state_a,
	input wire logic irq
);
	int c_oe; // pulled-low run
	int c_ah; // raw high run, input a
	int c_al; // raw low run, input a
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	// raw runs include the sync delay, so the filter bounds leave slack
	always_ff @(posedge mclk) begin
		c_oe <= irq_pulse_out_n_oe ? c_oe + 1 : 0;
		c_ah <= level_input_a_hi ? c_ah + 1 : 0;
		c_al <= level_input_a_lo ? c_al + 1 : 0;
	end
	sequence s_mclr; reg_wr && reg_addr == 4'h1 && reg_wdata[22:0] == 23'h0; endsequence
	property p_len; $fell(irq_pulse_out_n_oe) |-> c_oe == 14'h2710; endproperty
	property p_drv; irq_pulse_out_n_o == 1'b0; endproperty
	property p_rise; $rose(level_state_a) |-> c_ah >= 14'h1b58; endproperty
	property p_lvl; c_ah == 14'h1b6c |-> level_state_a; endproperty
	property p_fall; $fell(level_state_a) |-> c_al >= 14'h1b58; endproperty
	property p_bon; $rose(level_state_a) |-> ##[0:2] bias_on; endproperty
	property p_boff; $fell(bias_on) |-> $past(standby_mode) && !level_state_a; endproperty
	property p_mask; s_mclr |=> !irq; endproperty
	a_len: assert property (p_len) else $error("pulse length wrong");
	a_drv: assert property (p_drv) else $error("pin driven high");
	a_rise: assert property (p_rise) else $error("wake rose early");
	a_lvl: assert property (p_lvl) else $error("wake level lost");
	a_fall: assert property (p_fall) else $error("wake fell early");
	a_bon: assert property (p_bon) else $error("bias not started");
	a_boff: assert property (p_boff) else $error("bias stopped wrongly");
	a_mask: assert property (p_mask) else $error("masked irq high");
endmodule // wakirq_top_chk
bind wakirq_top wakirq_top_chk chk (.*);

// [test/wakirq_host.sv]
`timescale 1ns/10ps
// host end of the interrupt line: pull-up plus pulse counter
module wakirq_host (
	input wire logic mclk,
	input wire logic pin_o,
	input wire logic pin_oe,
	output int pulses,
	output int width
);
	wire logic pin; // resolved line level
	int run; // low samples so far
	// pull-up holds the line unless the device pulls
	assign pin = pin_oe ? pin_o : 1'b1;
	// a pulse counts only once the line is back high
	always @(posedge mclk) begin
		if (!pin) begin
			run <= run + 1;
		end else if (run != 0) begin
			pulses <= pulses + 1;
			width <= run;
			run <= 0;
		end
	end
endmodule // wakirq_host

// [test/wakirq_top_tb.sv]
`timescale 1ns/10ps
// register and pin tests of wake qualification and interrupts
module wakirq_top_tb;
	logic mclk = 1'b0, rst = 1'b1, standby_mode = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic level_input_a_hi = 1'b0, level_input_a_lo = 1'b1, level_input_a_alo = 1'b1;
	logic level_input_b_hi = 1'b0, level_input_b_lo = 1'b1, level_input_b_alo = 1'b1;
	logic [22:0] fault_evt = 23'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic irq_pulse_out_n_o, irq_pulse_out_n_oe, bias_on, level_state_a, level_state_b, irq;
	int fails, comparisons, cyc, pulses, width;
	wakirq_top uut (.*);
	wakirq_host host (.mclk(mclk), .pin_o(irq_pulse_out_n_o), .pin_oe(irq_pulse_out_n_oe),
		.pulses(pulses), .width(width));
	always #5 mclk = ~mclk;
	// one compare for every kind of result
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// gap after the strobe keeps one assignment per time step
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk("reg", e, reg_rdata);
		@(posedge mclk);
	endtask
	task automatic ev(input int i);
		fault_evt <= 23'h1 << i;
		@(posedge mclk);
		fault_evt <= 23'h0;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic complete_run;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 80000) begin
			fails++;
			complete_run();
		end
	end
	initial begin
		wt(10);
		rst <= 1'b0;
		wt(1);
		rd(4'h1, 32'h7fffff);
		rd(4'h2, 32'h0);
		rd(4'h0, 32'h0);
		rd(4'h3, 32'h0);
		rd(4'hf, 32'h0);
		ev(0);
		rd(4'h0, 32'h1);
		chk("irq", 32'h1, irq);
		wr(4'h0, 32'h1);
		chk("irq", 32'h0, irq);
		wt(10100);
		chk("pulses", 1, pulses);
		chk("width", 32'h2710, width);
		// every main source except the two wake bits; later ones coalesce into one more pulse
		for (int i = 0; i < 23; i++) begin
			if (i != 20 && i != 21) begin
				ev(i);
				rd(4'h0, 32'h1 << i);
				wr(4'h0, 32'h1 << i);
			end
		end
		wr(4'h4, 32'h1);
		rd(4'h0, 32'h400000);
		wr(4'h0, 32'h400000);
		wt(20100);
		chk("pulses", 3, pulses);
		wr(4'h2, 32'h7fffff);
		ev(4);
		wt(30);
		chk("pulses", 3, pulses);
		wr(4'h1, 32'h0);
		chk("irq", 32'h0, irq);
		wr(4'h0, 32'h7fffff);
		// short blip on b, then a long high on a
		level_input_b_hi <= 1'b1;
		wt(100);
		level_input_b_hi <= 1'b0;
		level_input_a_hi <= 1'b1;
		level_input_a_lo <= 1'b0;
		level_input_a_alo <= 1'b0;
		wt(7020);
		rd(4'h3, 32'h5);
		rd(4'h0, 32'h100000);
		level_input_a_hi <= 1'b0;
		level_input_a_lo <= 1'b1;
		level_input_a_alo <= 1'b1;
		wt(7010);
		rd(4'h3, 32'h4);
		standby_mode <= 1'b1;
		wt(10);
		rd(4'h3, 32'h0);
		// long high on b: state b, bias restart, wake b event
		level_input_b_hi <= 1'b1;
		level_input_b_lo <= 1'b0;
		level_input_b_alo <= 1'b0;
		wt(7020);
		rd(4'h3, 32'h6);
		rd(4'h0, 32'h300000);
		complete_run();
	end
endmodule // wakirq_top_tb
